// ==== cec_pkg.sv ====
// constants and types shared by the can control and error status block
`default_nettype none
package cec_pkg;

	// ----------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [15:0] IDX_CONTROL = 16'hff90;
	localparam logic [15:0] IDX_LAST_ERR = 16'hff92;
	localparam logic [15:0] IDX_ERR_STATE = 16'hff93;
	localparam logic [15:0] IDX_IRQ_STATUS = 16'hffa0;
	localparam logic [15:0] IDX_IRQ_MASK = 16'hffa1;
	localparam int ADDR_W = 18;

	// ----------------------------------------------------------------
	// control flag positions (set byte is +8 above the clear byte)
	// ----------------------------------------------------------------
	localparam int BIT_OPMODE_LO = 0;
	localparam int BIT_PSMODE_LO = 3;
	localparam int BIT_VALID = 5;
	localparam int BIT_ARB_RETRY = 6;
	localparam int BIT_CNT_CLR = 7;
	localparam int BIT_TX_BUSY = 8;
	localparam int BIT_RX_BUSY = 9;
	localparam int SET_OFFSET = 8;

	// ----------------------------------------------------------------
	// status register fields and interrupt event bits
	// ----------------------------------------------------------------
	localparam int BIT_RX_LEVEL_LO = 0;
	localparam int BIT_TX_LEVEL_LO = 2;
	localparam int BIT_BUS_OFF = 4;
	localparam int EV_PROTO_ERR = 0;
	localparam int EV_VALID_FRAME = 1;
	localparam int EV_BUS_OFF = 2;
	localparam int EV_W = 3;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_CONTROL = 8'h00;
	localparam logic [7:0] RST_LAST_ERR = 8'h00;
	localparam logic [7:0] RST_ERR_STATE = 8'h00;
	localparam logic [2:0] RST_IRQ = 3'h0;

	// ----------------------------------------------------------------
	// error counter thresholds and level codes
	// ----------------------------------------------------------------
	localparam int LVL_WARN = 96;
	localparam int LVL_PASSIVE = 128;
	localparam int LVL_BUS_OFF = 256;
	localparam logic [1:0] LEVEL_OK = 2'h0;
	localparam logic [1:0] LEVEL_WARN = 2'h1;
	localparam logic [1:0] LEVEL_PASSIVE = 2'h3;

	// last protocol error codes
	localparam logic [2:0] LEC_NONE = 3'h0;
	localparam logic [2:0] LEC_STUFF = 3'h1;
	localparam logic [2:0] LEC_FORM = 3'h2;
	localparam logic [2:0] LEC_ACK = 3'h3;
	localparam logic [2:0] LEC_BIT_DOM = 3'h4;
	localparam logic [2:0] LEC_BIT_REC = 3'h5;
	localparam logic [2:0] LEC_CRC = 3'h6;

	// operation modes
	typedef enum logic [2:0] {
		CEC_OP_INIT = 3'h0,
		CEC_OP_NORMAL = 3'h1,
		CEC_OP_NORMAL_ABT = 3'h2,
		CEC_OP_RX_ONLY = 3'h3,
		CEC_OP_SINGLE_SHOT = 3'h4,
		CEC_OP_SELF_TEST = 3'h5
	} cec_opmode_e;

	// power save modes
	typedef enum logic [1:0] {
		CEC_PS_NONE = 2'h0,
		CEC_PS_SLEEP = 2'h1,
		CEC_PS_STOP = 2'h3
	} cec_psmode_e;

endpackage
`default_nettype wire

// ==== cec_ctrl.sv ====
// can control, last error code and error state registers behind an apb slave
`default_nettype none

// Contract
// - counter-clear request sets only when its set and clear bits are both one
// - arbitration retry: set alone sets, clear alone clears, else unchanged
// - clear bit one clears valid-frame flag; software cannot set it
// - each power-save bit has its own set/clear pair, equal values hold
// - each operation-mode bit has its own set/clear pair, equal values hold
// - 8-bit last error code register, reset zero, code in bits 2:0
// - codes: none, stuff, form, ack, crc; code seven never produced
// - bit error codes 100 recessive-sent and 101 dominant-sent
// - last error code survives a change into initialization mode
// - nonzero writes to last error code ignored; writing zero clears it
// - read-only state register: bus-off, tx level, rx level, upper bits zero
// - bus-off bit high while transmit error count is 256 or more
// - tx level 00 below 96, 01 up to 127, 11 from 128
// - rx level 00 below 96, 01 up to 127, 11 from 128
// - clear request in init mode clears counters and state, then drops itself
// - operation mode decode: init, normal, abt, rx-only, single-shot, self-test
// - power save decode: none, sleep, stop; 10 prohibited
module cec_ctrl #(
	parameter int TX_CNT_W = 9,
	parameter int RX_CNT_W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [cec_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [TX_CNT_W-1:0] tx_err_count,
	input wire logic [RX_CNT_W-1:0] rx_err_count,
	input wire logic err_stuff,
	input wire logic err_form,
	input wire logic err_ack,
	input wire logic err_bit_dominant,
	input wire logic err_bit_recessive,
	input wire logic err_crc,
	input wire logic valid_frame_rx,
	input wire logic tx_busy,
	input wire logic rx_busy,
	output logic err_counter_clear,
	output logic [2:0] op_mode_sel,
	output logic [1:0] power_save_sel,
	output logic arb_loss_retry,
	output logic valid_frame,
	output logic mode_init,
	output logic mode_prohibited,
	output logic irq
);

	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	// the bus-off compare needs a count that can reach 256
	if (TX_CNT_W < 9 || TX_CNT_W > 16) begin : g_bad_tx
		$error("TX_CNT_W must be 9 to 16");
	end
	if (RX_CNT_W < 8 || RX_CNT_W > 16) begin : g_bad_rx
		$error("RX_CNT_W must be 8 to 16");
	end

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	localparam logic [cec_pkg::ADDR_W-1:0] A_CONTROL = {cec_pkg::IDX_CONTROL, 2'b00};
	localparam logic [cec_pkg::ADDR_W-1:0] A_LAST_ERR = {cec_pkg::IDX_LAST_ERR, 2'b00};
	localparam logic [cec_pkg::ADDR_W-1:0] A_ERR_STATE = {cec_pkg::IDX_ERR_STATE, 2'b00};
	localparam logic [cec_pkg::ADDR_W-1:0] A_IRQ_STATUS = {cec_pkg::IDX_IRQ_STATUS, 2'b00};
	localparam logic [cec_pkg::ADDR_W-1:0] A_IRQ_MASK = {cec_pkg::IDX_IRQ_MASK, 2'b00};

	logic setup_phase;
	logic wr_access;
	logic hit_control;
	logic hit_last_err;
	logic hit_err_state;
	logic hit_irq_status;
	logic hit_irq_mask;
	logic hit_any;

	// the slave never stretches a transfer, so access is always one cycle
	assign pready = 1'b1;
	assign setup_phase = psel && !penable;
	assign wr_access = psel && penable && pwrite;
	assign hit_control = (paddr == A_CONTROL);
	assign hit_last_err = (paddr == A_LAST_ERR);
	assign hit_err_state = (paddr == A_ERR_STATE);
	assign hit_irq_status = (paddr == A_IRQ_STATUS);
	assign hit_irq_mask = (paddr == A_IRQ_MASK);
	assign hit_any = hit_control || hit_last_err || hit_err_state || hit_irq_status
		|| hit_irq_mask;

	// byte lane 1 carries the set half, lane 0 the clear half; a lane left off reads as zero
	logic [7:0] wr_set;
	logic [7:0] wr_clr;
	logic ctrl_wr;

	assign ctrl_wr = wr_access && hit_control;
	assign wr_set = (ctrl_wr && pstrb[1]) ? pwdata[15:8] : 8'h00;
	assign wr_clr = (ctrl_wr && pstrb[0]) ? pwdata[7:0] : 8'h00;

	// ----------------------------------------------------------------
	// control flags
	// ----------------------------------------------------------------
	logic cnt_clr_req;
	logic clear_fire;

	// the request acts only while initialization mode is selected
	assign mode_init = (op_mode_sel == 3'(cec_pkg::CEC_OP_INIT));
	assign clear_fire = cnt_clr_req && mode_init;

	// counter-clear request: both halves one sets it, completion drops it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_clr_req <= cec_pkg::RST_CONTROL[cec_pkg::BIT_CNT_CLR];
		end else if (wr_set[cec_pkg::BIT_CNT_CLR] && wr_clr[cec_pkg::BIT_CNT_CLR]) begin
			cnt_clr_req <= 1'b1;
		end else if (clear_fire) begin
			cnt_clr_req <= 1'b0;
		end
	end

	// one-cycle clear strobe towards the error counters
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			err_counter_clear <= 1'b0;
		end else begin
			err_counter_clear <= clear_fire;
		end
	end

	// arbitration retry flag, only meaningful in single-shot mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			arb_loss_retry <= cec_pkg::RST_CONTROL[cec_pkg::BIT_ARB_RETRY];
		end else if (wr_set[cec_pkg::BIT_ARB_RETRY] != wr_clr[cec_pkg::BIT_ARB_RETRY]) begin
			arb_loss_retry <= wr_set[cec_pkg::BIT_ARB_RETRY];
		end
	end

	// valid frame flag: a frame arriving with the clear wins, so none is lost
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			valid_frame <= cec_pkg::RST_CONTROL[cec_pkg::BIT_VALID];
		end else if (valid_frame_rx) begin
			valid_frame <= 1'b1;
		end else if (wr_clr[cec_pkg::BIT_VALID]) begin
			valid_frame <= 1'b0;
		end
	end

	// power save and operation mode bits share one per-bit set/clear cell
	logic [4:0] mode_bits;

	for (genvar i = 0; i < 5; i++) begin : g_mode_bit
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				mode_bits[i] <= cec_pkg::RST_CONTROL[cec_pkg::BIT_OPMODE_LO + i];
			end else if (wr_set[cec_pkg::BIT_OPMODE_LO + i]
				!= wr_clr[cec_pkg::BIT_OPMODE_LO + i]) begin
				mode_bits[i] <= wr_set[cec_pkg::BIT_OPMODE_LO + i];
			end
		end
	end

	assign op_mode_sel = mode_bits[2:0];
	assign power_save_sel = mode_bits[4:3];

	// ----------------------------------------------------------------
	// mode decode
	// ----------------------------------------------------------------
	logic op_bad;
	logic ps_bad;

	// prohibited combinations are flagged so the frame engine can hold off
	always_comb begin
		case (op_mode_sel)
			3'(cec_pkg::CEC_OP_INIT),
			3'(cec_pkg::CEC_OP_NORMAL),
			3'(cec_pkg::CEC_OP_NORMAL_ABT),
			3'(cec_pkg::CEC_OP_RX_ONLY),
			3'(cec_pkg::CEC_OP_SINGLE_SHOT),
			3'(cec_pkg::CEC_OP_SELF_TEST): begin
				op_bad = 1'b0;
			end
			default: begin
				op_bad = 1'b1;
			end
		endcase
	end

	always_comb begin
		case (power_save_sel)
			2'(cec_pkg::CEC_PS_NONE),
			2'(cec_pkg::CEC_PS_SLEEP),
			2'(cec_pkg::CEC_PS_STOP): begin
				ps_bad = 1'b0;
			end
			default: begin
				ps_bad = 1'b1;
			end
		endcase
	end

	assign mode_prohibited = op_bad || ps_bad;

	// ----------------------------------------------------------------
	// last protocol error code
	// ----------------------------------------------------------------
	logic [2:0] last_err_code;
	logic [2:0] next_err_code;
	logic err_event;

	// one code per cycle; bit errors first since they mask the later checks
	always_comb begin
		next_err_code = cec_pkg::LEC_NONE;
		if (err_bit_dominant) begin
			next_err_code = cec_pkg::LEC_BIT_DOM;
		end else if (err_bit_recessive) begin
			next_err_code = cec_pkg::LEC_BIT_REC;
		end else if (err_stuff) begin
			next_err_code = cec_pkg::LEC_STUFF;
		end else if (err_form) begin
			next_err_code = cec_pkg::LEC_FORM;
		end else if (err_ack) begin
			next_err_code = cec_pkg::LEC_ACK;
		end else if (err_crc) begin
			next_err_code = cec_pkg::LEC_CRC;
		end
	end

	assign err_event = err_stuff || err_form || err_ack || err_bit_dominant
		|| err_bit_recessive || err_crc;

	// mode changes never touch the code; a new error beats a clearing write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_err_code <= cec_pkg::RST_LAST_ERR[2:0];
		end else if (err_event) begin
			last_err_code <= next_err_code;
		end else if (wr_access && hit_last_err && pstrb[0] && pwdata[7:0] == 8'h00) begin
			last_err_code <= cec_pkg::LEC_NONE;
		end
	end

	// ----------------------------------------------------------------
	// error state register
	// ----------------------------------------------------------------
	logic [7:0] err_state;
	logic [7:0] next_err_state;
	logic [1:0] tx_level;
	logic [1:0] rx_level;
	logic bus_off_flag;

	// level codes; the undefined code 10 has no path here
	always_comb begin
		if (tx_err_count >= TX_CNT_W'(cec_pkg::LVL_PASSIVE)) begin
			tx_level = cec_pkg::LEVEL_PASSIVE;
		end else if (tx_err_count >= TX_CNT_W'(cec_pkg::LVL_WARN)) begin
			tx_level = cec_pkg::LEVEL_WARN;
		end else begin
			tx_level = cec_pkg::LEVEL_OK;
		end
		if (rx_err_count >= RX_CNT_W'(cec_pkg::LVL_PASSIVE)) begin
			rx_level = cec_pkg::LEVEL_PASSIVE;
		end else if (rx_err_count >= RX_CNT_W'(cec_pkg::LVL_WARN)) begin
			rx_level = cec_pkg::LEVEL_WARN;
		end else begin
			rx_level = cec_pkg::LEVEL_OK;
		end
	end

	assign bus_off_flag = (tx_err_count >= TX_CNT_W'(cec_pkg::LVL_BUS_OFF));

	always_comb begin
		next_err_state = 8'h00;
		next_err_state[cec_pkg::BIT_BUS_OFF] = bus_off_flag;
		next_err_state[cec_pkg::BIT_TX_LEVEL_LO +: 2] = tx_level;
		next_err_state[cec_pkg::BIT_RX_LEVEL_LO +: 2] = rx_level;
	end

	// follows the counters one cycle late; held at zero until the counters have cleared
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			err_state <= cec_pkg::RST_ERR_STATE;
		end else if (clear_fire || err_counter_clear) begin
			err_state <= cec_pkg::RST_ERR_STATE;
		end else begin
			err_state <= next_err_state;
		end
	end

	// ----------------------------------------------------------------
	// interrupts
	// ----------------------------------------------------------------
	logic [cec_pkg::EV_W-1:0] irq_status;
	logic [cec_pkg::EV_W-1:0] irq_mask;
	logic [cec_pkg::EV_W-1:0] events;
	logic [cec_pkg::EV_W-1:0] w1c;
	logic bus_off_seen;

	// entering bus-off is an edge of the registered state bit
	assign bus_off_seen = next_err_state[cec_pkg::BIT_BUS_OFF]
		&& !err_state[cec_pkg::BIT_BUS_OFF] && !clear_fire && !err_counter_clear;

	always_comb begin
		events = '0;
		events[cec_pkg::EV_PROTO_ERR] = err_event;
		events[cec_pkg::EV_VALID_FRAME] = valid_frame_rx;
		events[cec_pkg::EV_BUS_OFF] = bus_off_seen;
	end

	assign w1c = (wr_access && hit_irq_status && pstrb[0])
		? pwdata[cec_pkg::EV_W-1:0] : '0;

	// sticky: an event in the clearing cycle keeps its bit set
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status <= cec_pkg::RST_IRQ;
		end else begin
			irq_status <= (irq_status & ~w1c) | events;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask <= cec_pkg::RST_IRQ;
		end else if (wr_access && hit_irq_mask && pstrb[0]) begin
			irq_mask <= pwdata[cec_pkg::EV_W-1:0];
		end
	end

	assign irq = |(irq_status & irq_mask);

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	logic [31:0] rd_mux;

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (hit_control) begin
			rd_mux[cec_pkg::BIT_OPMODE_LO +: 5] = mode_bits;
			rd_mux[cec_pkg::BIT_VALID] = valid_frame;
			rd_mux[cec_pkg::BIT_ARB_RETRY] = arb_loss_retry;
			rd_mux[cec_pkg::BIT_CNT_CLR] = cnt_clr_req;
			rd_mux[cec_pkg::BIT_TX_BUSY] = tx_busy;
			rd_mux[cec_pkg::BIT_RX_BUSY] = rx_busy;
		end else if (hit_last_err) begin
			rd_mux[2:0] = last_err_code;
		end else if (hit_err_state) begin
			rd_mux[7:0] = err_state;
		end else if (hit_irq_status) begin
			rd_mux[cec_pkg::EV_W-1:0] = irq_status;
		end else if (hit_irq_mask) begin
			rd_mux[cec_pkg::EV_W-1:0] = irq_mask;
		end
	end

	// read data and error are captured in the setup cycle and stand through access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (setup_phase) begin
			prdata <= pwrite ? 32'h0000_0000 : rd_mux;
			pslverr <= !hit_any;
		end
	end

	// an unmapped write is dropped; every hit_ term above is zero for it

endmodule
`default_nettype wire

// ==== cec_ctrl_sva.sv ====
// concurrent properties watching the control and error status block ports
`default_nettype none
module cec_ctrl_sva (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [cec_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic valid_frame_rx,
	input wire logic err_counter_clear,
	input wire logic [2:0] op_mode_sel,
	input wire logic [1:0] power_save_sel,
	input wire logic arb_loss_retry,
	input wire logic valid_frame,
	input wire logic mode_init
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------------------------------
	// access decode
	// ----------------------------------------------------------------
	// a control write only counts when both low byte lanes are present
	logic ctl_wr;
	logic lec_rd;
	logic st_rd;
	assign ctl_wr = psel && penable && pwrite && pstrb[1:0] == 2'h3
		&& paddr == {cec_pkg::IDX_CONTROL, 2'h0};
	assign lec_rd = psel && penable && !pwrite && paddr == {cec_pkg::IDX_LAST_ERR, 2'h0};
	assign st_rd = psel && penable && !pwrite && paddr == {cec_pkg::IDX_ERR_STATE, 2'h0};

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	// request raised in init with no mode bit set, so it completes at once
	sequence s_clr_req;
		ctl_wr && pwdata[15] && pwdata[7] && pwdata[10:8] == 3'h0 && mode_init;
	endsequence
	sequence s_clr_pulse;
		##2 err_counter_clear;
	endsequence
	a_clr_request: assert property (s_clr_req |-> s_clr_pulse)
		else $error("counter clear pulse missing");
	a_clr_only_init: assert property (err_counter_clear |-> $past(mode_init))
		else $error("counter clear outside init");
	a_mode_set: assert property (ctl_wr && pwdata[8] && !pwdata[0] |=> op_mode_sel[0])
		else $error("mode bit not set");
	a_mode_hold: assert property (ctl_wr && pwdata[10] == pwdata[2] |=> $stable(op_mode_sel[2]))
		else $error("mode bit changed on equal pair");
	a_ps_clear: assert property (ctl_wr && pwdata[4] && !pwdata[12] |=> !power_save_sel[1])
		else $error("power save bit not cleared");
	a_retry_pair: assert property (ctl_wr && pwdata[14] != pwdata[6]
		|=> arb_loss_retry == $past(pwdata[14]))
		else $error("retry flag wrong after pair");
	a_valid_clear: assert property (ctl_wr && pwdata[5] && !valid_frame_rx |=> !valid_frame)
		else $error("valid flag not cleared");
	a_valid_source: assert property ($rose(valid_frame) |-> $past(valid_frame_rx))
		else $error("valid flag set without a frame");
	a_lec_read: assert property (lec_rd |-> prdata[7:3] == 5'h0 && prdata[2:0] != 3'h7)
		else $error("bad last error read value");
	a_state_read: assert property (st_rd |-> prdata[7:5] == 3'h0
		&& prdata[3:2] != 2'h2 && prdata[1:0] != 2'h2)
		else $error("bad error state read value");
endmodule
`default_nettype wire

// ==== cec_bus_model.sv ====
// behavioural frame engine and error counters standing in for the bus side
`default_nettype none
module cec_bus_model (
	input wire logic pclk,
	input wire logic err_counter_clear,
	output logic [8:0] tx_err_count,
	output logic [7:0] rx_err_count,
	output logic [5:0] err_ev,
	output logic valid_frame_rx,
	output logic tx_busy,
	output logic rx_busy
);
	timeunit 1ns;
	timeprecision 1ns;
	// counters clear when the block asks, as real error counters would
	initial begin
		tx_err_count = 9'h0;
		rx_err_count = 8'h0;
		err_ev = 6'h0;
		valid_frame_rx = 1'b0;
		{rx_busy, tx_busy} = 2'h0;
		forever begin
			@(posedge pclk);
			if (err_counter_clear === 1'b1) begin
				tx_err_count <= 9'h0;
				rx_err_count <= 8'h0;
			end
		end
	end
	// counter values and busy levels change together just after an edge
	task levels(input logic [8:0] t, input logic [7:0] r, input logic [1:0] b);
		@(posedge pclk);
		tx_err_count <= t;
		rx_err_count <= r;
		{rx_busy, tx_busy} <= b;
	endtask
	// one-cycle event: 0 stuff, 1 form, 2 ack, 3 sent recessive saw dominant,
	// 4 sent dominant saw recessive, 5 crc, 6 good frame
	task frame_event(input int idx);
		@(posedge pclk);
		if (idx == 6)
			valid_frame_rx <= 1'b1;
		else
			err_ev[idx] <= 1'b1;
		@(posedge pclk);
		err_ev <= 6'h0;
		valid_frame_rx <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ==== can_ctrl_error_status_tb_top.sv ====
// self-checking bench for the control and error status block
`default_nettype none
module can_ctrl_error_status_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [15:0] CTL = cec_pkg::IDX_CONTROL;
	localparam logic [15:0] LEC = cec_pkg::IDX_LAST_ERR;
	localparam logic [15:0] ST = cec_pkg::IDX_ERR_STATE;
	localparam logic [15:0] IST = cec_pkg::IDX_IRQ_STATUS;
	localparam logic [15:0] IMK = cec_pkg::IDX_IRQ_MASK;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, serr;
	logic [17:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic [8:0] tx_err_count;
	logic [7:0] rx_err_count;
	logic [5:0] err_ev;
	logic valid_frame_rx, tx_busy, rx_busy, err_counter_clear, arb_loss_retry, valid_frame;
	logic mode_init, mode_prohibited, irq;
	logic [2:0] op_mode_sel;
	logic [1:0] power_save_sel;
	int num_errors, comparisons, cycles, clr_seen, i, b, v;
	int pos[6] = '{0, 1, 2, 3, 4, 6};
	int txv[7] = '{95, 96, 127, 128, 255, 256, 0};
	int rxv[7] = '{0, 95, 96, 127, 128, 255, 0};

	cec_ctrl i_cec_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .tx_err_count(tx_err_count),
		.rx_err_count(rx_err_count), .err_stuff(err_ev[0]), .err_form(err_ev[1]),
		.err_ack(err_ev[2]), .err_bit_dominant(err_ev[3]), .err_bit_recessive(err_ev[4]),
		.err_crc(err_ev[5]), .valid_frame_rx(valid_frame_rx), .tx_busy(tx_busy),
		.rx_busy(rx_busy), .err_counter_clear(err_counter_clear), .op_mode_sel(op_mode_sel),
		.power_save_sel(power_save_sel), .arb_loss_retry(arb_loss_retry),
		.valid_frame(valid_frame), .mode_init(mode_init), .mode_prohibited(mode_prohibited),
		.irq(irq));
	cec_bus_model i_cec_bus_model (.pclk(pclk), .err_counter_clear(err_counter_clear),
		.tx_err_count(tx_err_count), .rx_err_count(rx_err_count), .err_ev(err_ev),
		.valid_frame_rx(valid_frame_rx), .tx_busy(tx_busy), .rx_busy(rx_busy));

	// clock, pulse counter and hang guard
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cycles++;
		if (err_counter_clear === 1'b1)
			clr_seen++;
		if (cycles == 20000) begin
			num_errors++;
			test_done();
		end
	end

	// ----------------------------------------------------------------
	// bus tasks and checks
	// ----------------------------------------------------------------
	task automatic xfer(input logic [15:0] idx, input logic wr, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx, 2'h0};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		// no local limit: a stuck slave is caught by the cycle guard as a mismatch
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [15:0] idx, input logic [31:0] d);
		xfer(idx, 1'b1, d);
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic rdchk(input string nm, input logic [15:0] idx, input logic [31:0] e);
		xfer(idx, 1'b0, 32'h0);
		chk(nm, e, rd);
	endtask
	function automatic logic [1:0] lvl(input int n);
		return n < 96 ? 2'h0 : (n < 128 ? 2'h1 : 2'h3);
	endfunction
	task test_done();
		if (num_errors == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		pstrb = 4'hf;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rdchk("control", CTL, 32'h0);
		rdchk("last_err", LEC, 32'h0);
		rdchk("err_state", ST, 32'h0);
		rdchk("unmapped", 16'hff99, 32'h0);
		chk("unmapped_err", 32'h1, serr);
		// each pair: set alone, both, neither, clear alone, both again
		for (i = 0; i < 6; i++) begin
			b = pos[i];
			wr(CTL, 32'h1 << (b + 8));
			rdchk("ctl_set", CTL, 32'h1 << b);
			wr(CTL, 32'h101 << b);
			wr(CTL, 32'h0);
			rdchk("ctl_hold1", CTL, 32'h1 << b);
			wr(CTL, 32'h1 << b);
			rdchk("ctl_clr", CTL, 32'h0);
			wr(CTL, 32'h101 << b);
			rdchk("ctl_hold0", CTL, 32'h0);
		end
		for (v = 0; v < 8; v++) begin
			wr(CTL, {16'h0, 5'h0, v[2:0], 5'h0, ~v[2:0]});
			@(negedge pclk);
			chk("op_mode", v, op_mode_sel);
			chk("init", v == 0, mode_init);
			chk("op_prohib", v > 5, mode_prohibited);
		end
		wr(CTL, 32'h7);
		for (v = 0; v < 4; v++) begin
			wr(CTL, {16'h0, 3'h0, v[1:0], 3'h0, 3'h0, ~v[1:0], 3'h0});
			@(negedge pclk);
			chk("ps_mode", v, power_save_sel);
			chk("ps_prohib", v == 2, mode_prohibited);
		end
		wr(CTL, 32'h18);
		// clear request held in normal mode, served on return to init
		i_cec_bus_model.levels(9'd300, 8'd130, 2'h3);
		wr(CTL, 32'h0100);
		wr(CTL, 32'h8080);
		rdchk("clr_req", CTL, 32'h381);
		rdchk("state_hi", ST, 32'h1f);
		wr(CTL, 32'h8000);
		wr(CTL, 32'h0080);
		rdchk("clr_req_kept", CTL, 32'h381);
		v = clr_seen;
		wr(CTL, 32'h0001);
		repeat (3) @(posedge pclk);
		chk("clr_pulse", v + 1, clr_seen);
		rdchk("clr_done", CTL, 32'h300);
		rdchk("state_clr", ST, 32'h0);
		// request raised while already in init is served at once
		v = clr_seen;
		wr(CTL, 32'h8080);
		repeat (3) @(posedge pclk);
		chk("clr_init_pulse", v + 1, clr_seen);
		rdchk("clr_init_done", CTL, 32'h300);
		// thresholds either side of each level boundary
		for (i = 0; i < 7; i++) begin
			i_cec_bus_model.levels(txv[i], rxv[i], 2'h0);
			repeat (2) @(posedge pclk);
			rdchk("levels", ST, {27'h0, txv[i] > 255, lvl(txv[i]), lvl(rxv[i])});
		end
		// every error kind leaves its own code
		wr(IST, 32'h7);
		for (i = 0; i < 6; i++) begin
			i_cec_bus_model.frame_event(i);
			rdchk("lec_code", LEC, i + 1);
		end
		// interrupt raised, cleared by writing one, then masked
		wr(IST, 32'h7);
		wr(IMK, 32'h1);
		i_cec_bus_model.frame_event(0);
		@(negedge pclk);
		chk("irq_on", 32'h1, irq);
		wr(IST, 32'h1);
		@(negedge pclk);
		chk("irq_off", 32'h0, irq);
		wr(IMK, 32'h0);
		i_cec_bus_model.frame_event(1);
		@(negedge pclk);
		chk("irq_masked", 32'h0, irq);
		rdchk("irq_status", IST, 32'h1);
		wr(LEC, 32'h5);
		rdchk("lec_keep", LEC, 32'h2);
		wr(CTL, 32'h0100);
		wr(CTL, 32'h0001);
		rdchk("lec_init", LEC, 32'h2);
		wr(LEC, 32'h0);
		rdchk("lec_zero", LEC, 32'h0);
		// valid flag: set by a frame only, cleared by its clear bit
		i_cec_bus_model.frame_event(6);
		rdchk("valid_set", CTL, 32'h20);
		wr(CTL, 32'h0);
		rdchk("valid_keep", CTL, 32'h20);
		wr(CTL, 32'h20);
		rdchk("valid_clr", CTL, 32'h0);
		wr(CTL, 32'h2000);
		rdchk("valid_nosoft", CTL, 32'h0);
		test_done();
	end
endmodule

bind cec_ctrl cec_ctrl_sva i_cec_ctrl_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
	.prdata(prdata), .valid_frame_rx(valid_frame_rx), .err_counter_clear(err_counter_clear),
	.op_mode_sel(op_mode_sel), .power_save_sel(power_save_sel),
	.arb_loss_retry(arb_loss_retry), .valid_frame(valid_frame), .mode_init(mode_init));
`default_nettype wire
